//--- hw/dctg_regs.svh
// Register offsets, field positions, reset values and timing constants of the time code generator
`ifndef DCTG_REGS_SVH
`define DCTG_REGS_SVH

`define DCTG_ADDR_W 12
`define DCTG_OFS_CTRL 12'h000
`define DCTG_OFS_TIME 12'h004
`define DCTG_OFS_DATE 12'h008
`define DCTG_OFS_FLAGS 12'h00C
`define DCTG_OFS_QUALITY 12'h010
`define DCTG_OFS_BIN_SECONDS 12'h014
`define DCTG_OFS_STATUS 12'h018

`define DCTG_CTRL_EXT_BIT 0
`define DCTG_TIME_SEC_LSB 0
`define DCTG_TIME_MIN_LSB 8
`define DCTG_TIME_HOUR_LSB 16
`define DCTG_DATE_DAY_LSB 0
`define DCTG_DATE_YEAR_LSB 16
`define DCTG_FLAGS_LEAP_PEND_BIT 0
`define DCTG_FLAGS_SUMMER_PEND_BIT 1
`define DCTG_FLAGS_SUMMER_BIT 2
`define DCTG_FLAGS_TZ_SIGN_BIT 3
`define DCTG_FLAGS_TZ_HOURS_LSB 4
`define DCTG_FLAGS_TZ_HALF_BIT 8
`define DCTG_STATUS_ENABLED_BIT 0
`define DCTG_STATUS_SEND_BIT 1
`define DCTG_STATUS_FIRST_SYNC_BIT 2
`define DCTG_STATUS_IDX_LSB 8

`define DCTG_RST_QUALITY 4'hF
`define DCTG_RST_CTRL 1'b0

`define DCTG_CLK_HZ 25000000
`define DCTG_ELEM_US 10000
`define DCTG_ZERO_US 2000
`define DCTG_ONE_US 5000
`define DCTG_MARK_US 8000
`define DCTG_ELEMS 100
`define DCTG_CNT_W 18

`endif

//--- hw/dctg_pkg.sv
// Types shared by the time code generator
package dctg_pkg;
  typedef enum logic [0:0] {
    DCTG_IDLE = 1'b0,
    DCTG_SEND = 1'b1
  } dctg_state_e;
  typedef logic [99:0] dctg_frame_t;
endpackage

//--- hw/dctg_time_code_gen.sv
// Pulse-width-coded DC level time code generator with APB register access
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "dctg_regs.svh"

module dctg_time_code_gen #(
  parameter int ELEM_CYCLES = `DCTG_ELEM_US * (`DCTG_CLK_HZ / 1000000),
  parameter int ZERO_CYCLES = `DCTG_ZERO_US * (`DCTG_CLK_HZ / 1000000),
  parameter int ONE_CYCLES = `DCTG_ONE_US * (`DCTG_CLK_HZ / 1000000),
  parameter int MARK_CYCLES = `DCTG_MARK_US * (`DCTG_CLK_HZ / 1000000)
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_pps,
  input wire logic i_synced,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`DCTG_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_time_code,
  output logic o_outputs_enabled_indicator
);

  localparam logic [`DCTG_CNT_W-1:0] ELEM_LAST = `DCTG_CNT_W'(ELEM_CYCLES - 1);
  localparam logic [`DCTG_CNT_W-1:0] ZERO_W = `DCTG_CNT_W'(ZERO_CYCLES);
  localparam logic [`DCTG_CNT_W-1:0] ONE_W = `DCTG_CNT_W'(ONE_CYCLES);
  localparam logic [`DCTG_CNT_W-1:0] MARK_W = `DCTG_CNT_W'(MARK_CYCLES);
  localparam logic [6:0] LAST_IDX = 7'(`DCTG_ELEMS - 1);

  logic ext_format;
  logic [6:0] sec_bcd;
  logic [6:0] min_bcd;
  logic [5:0] hour_bcd;
  logic [9:0] day_bcd;
  logic [7:0] year_bcd;
  logic leap_pending_flag;
  logic summer_pending;
  logic summer_time_flag;
  logic tz_sign;
  logic [3:0] tz_hours;
  logic tz_half;
  logic [3:0] clock_quality_figure;
  logic [16:0] binary_seconds_of_day;
  logic first_sync_done;
  logic synced_d;
  dctg_pkg::dctg_state_e state;
  dctg_pkg::dctg_frame_t frame;
  dctg_pkg::dctg_frame_t next_frame;
  logic [6:0] idx;
  logic [3:0] ones;
  logic [`DCTG_CNT_W-1:0] cyc;
  logic [`DCTG_CNT_W-1:0] width;
  logic is_marker;
  logic apb_access;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] next_rdata;
  logic leap_direction_flag;
  logic first_sync_event;

  // Only additions are supported, so direction is a constant zero
  assign leap_direction_flag = 1'b0;
  assign first_sync_event = i_synced && !synced_d && !first_sync_done;

  // APB: one wait state so pready and prdata come straight from flops
  assign apb_access = i_psel && i_penable;
  assign wr_en = apb_access && o_pready && i_pwrite && addr_ok;
  assign rd_en = apb_access && !o_pready && !i_pwrite;

  always_comb begin
    addr_ok = 1'b1;
    next_rdata = 32'h0;
    unique case (i_paddr)
      `DCTG_OFS_CTRL: next_rdata[`DCTG_CTRL_EXT_BIT] = ext_format;
      `DCTG_OFS_TIME: begin
        next_rdata[`DCTG_TIME_SEC_LSB +: 7] = sec_bcd;
        next_rdata[`DCTG_TIME_MIN_LSB +: 7] = min_bcd;
        next_rdata[`DCTG_TIME_HOUR_LSB +: 6] = hour_bcd;
      end
      `DCTG_OFS_DATE: begin
        next_rdata[`DCTG_DATE_DAY_LSB +: 10] = day_bcd;
        next_rdata[`DCTG_DATE_YEAR_LSB +: 8] = year_bcd;
      end
      `DCTG_OFS_FLAGS: begin
        next_rdata[`DCTG_FLAGS_LEAP_PEND_BIT] = leap_pending_flag;
        next_rdata[`DCTG_FLAGS_SUMMER_PEND_BIT] = summer_pending;
        next_rdata[`DCTG_FLAGS_SUMMER_BIT] = summer_time_flag;
        next_rdata[`DCTG_FLAGS_TZ_SIGN_BIT] = tz_sign;
        next_rdata[`DCTG_FLAGS_TZ_HOURS_LSB +: 4] = tz_hours;
        next_rdata[`DCTG_FLAGS_TZ_HALF_BIT] = tz_half;
      end
      `DCTG_OFS_QUALITY: next_rdata[3:0] = clock_quality_figure;
      `DCTG_OFS_BIN_SECONDS: next_rdata[16:0] = binary_seconds_of_day;
      `DCTG_OFS_STATUS: begin
        next_rdata[`DCTG_STATUS_ENABLED_BIT] = o_outputs_enabled_indicator;
        next_rdata[`DCTG_STATUS_SEND_BIT] = (state == dctg_pkg::DCTG_SEND);
        next_rdata[`DCTG_STATUS_FIRST_SYNC_BIT] = first_sync_done;
        next_rdata[`DCTG_STATUS_IDX_LSB +: 7] = idx;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
    end else begin
      o_pready <= apb_access && !o_pready;
      o_pslverr <= apb_access && !o_pready && !addr_ok;
      if (rd_en) begin
        o_prdata <= next_rdata;
      end
    end
  end

  // Time and flag registers; software loads the values for the next second before its PPS
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ext_format <= `DCTG_RST_CTRL;
      sec_bcd <= 7'h00;
      min_bcd <= 7'h00;
      hour_bcd <= 6'h00;
      day_bcd <= 10'h000;
      year_bcd <= 8'h00;
      leap_pending_flag <= 1'b0;
      summer_pending <= 1'b0;
      summer_time_flag <= 1'b0;
      tz_sign <= 1'b0;
      tz_hours <= 4'h0;
      tz_half <= 1'b0;
      binary_seconds_of_day <= 17'h00000;
    end else if (wr_en) begin
      unique case (i_paddr)
        `DCTG_OFS_CTRL: ext_format <= i_pwdata[`DCTG_CTRL_EXT_BIT];
        `DCTG_OFS_TIME: begin
          sec_bcd <= i_pwdata[`DCTG_TIME_SEC_LSB +: 7];
          min_bcd <= i_pwdata[`DCTG_TIME_MIN_LSB +: 7];
          hour_bcd <= i_pwdata[`DCTG_TIME_HOUR_LSB +: 6];
        end
        `DCTG_OFS_DATE: begin
          day_bcd <= i_pwdata[`DCTG_DATE_DAY_LSB +: 10];
          year_bcd <= i_pwdata[`DCTG_DATE_YEAR_LSB +: 8];
        end
        `DCTG_OFS_FLAGS: begin
          leap_pending_flag <= i_pwdata[`DCTG_FLAGS_LEAP_PEND_BIT];
          summer_pending <= i_pwdata[`DCTG_FLAGS_SUMMER_PEND_BIT];
          summer_time_flag <= i_pwdata[`DCTG_FLAGS_SUMMER_BIT];
          tz_sign <= i_pwdata[`DCTG_FLAGS_TZ_SIGN_BIT];
          tz_hours <= i_pwdata[`DCTG_FLAGS_TZ_HOURS_LSB +: 4];
          tz_half <= i_pwdata[`DCTG_FLAGS_TZ_HALF_BIT];
        end
        `DCTG_OFS_BIN_SECONDS: binary_seconds_of_day <= i_pwdata[16:0];
        default: ;
      endcase
    end
  end

  // First lock clears the quality figure; it wins over a software write in the same cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      clock_quality_figure <= `DCTG_RST_QUALITY;
      first_sync_done <= 1'b0;
      synced_d <= 1'b0;
    end else begin
      synced_d <= i_synced;
      if (first_sync_event) begin
        clock_quality_figure <= 4'h0;
        first_sync_done <= 1'b1;
      end else if (wr_en && i_paddr == `DCTG_OFS_QUALITY) begin
        clock_quality_figure <= i_pwdata[3:0];
      end
    end
  end

  // Frame image; marker slots hold zero and are shaped by position instead
  always_comb begin
    next_frame = '0;
    next_frame[4:1] = sec_bcd[3:0];
    next_frame[8:6] = sec_bcd[6:4];
    next_frame[13:10] = min_bcd[3:0];
    next_frame[17:15] = min_bcd[6:4];
    next_frame[23:20] = hour_bcd[3:0];
    next_frame[26:25] = hour_bcd[5:4];
    next_frame[33:30] = day_bcd[3:0];
    next_frame[38:35] = day_bcd[7:4];
    next_frame[41:40] = day_bcd[9:8];
    next_frame[53:50] = year_bcd[3:0];
    next_frame[54] = 1'b0;
    next_frame[58:55] = year_bcd[7:4];
    next_frame[60] = leap_pending_flag;
    next_frame[61] = leap_direction_flag;
    next_frame[62] = summer_pending;
    next_frame[63] = summer_time_flag;
    next_frame[64] = tz_sign;
    next_frame[68:65] = tz_hours;
    next_frame[70] = tz_half;
    next_frame[74:71] = clock_quality_figure;
    next_frame[75] = ^next_frame[74:0];
    if (ext_format) begin
      next_frame[88:80] = binary_seconds_of_day[8:0];
      next_frame[97:90] = binary_seconds_of_day[16:9];
    end
  end

  // Frame start at index 0, markers where the units digit is nine
  assign is_marker = (idx == 7'h00) || (ones == 4'h9);

  always_comb begin
    if (is_marker) begin
      width = MARK_W;
    end else if (frame[idx]) begin
      width = ONE_W;
    end else begin
      width = ZERO_W;
    end
  end

  // Sequencer; a PPS while synced always restarts the frame so drift never accumulates
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state <= dctg_pkg::DCTG_IDLE;
      frame <= '0;
      idx <= 7'h00;
      ones <= 4'h0;
      cyc <= '0;
    end else if (!i_synced) begin
      state <= dctg_pkg::DCTG_IDLE;
      idx <= 7'h00;
      ones <= 4'h0;
      cyc <= '0;
    end else if (i_pps) begin
      state <= dctg_pkg::DCTG_SEND;
      frame <= next_frame;
      idx <= 7'h00;
      ones <= 4'h0;
      cyc <= '0;
    end else if (state == dctg_pkg::DCTG_SEND) begin
      if (cyc == ELEM_LAST) begin
        cyc <= '0;
        if (idx == LAST_IDX) begin
          state <= dctg_pkg::DCTG_IDLE;
          idx <= 7'h00;
          ones <= 4'h0;
        end else begin
          idx <= idx + 7'h01;
          ones <= (ones == 4'h9) ? 4'h0 : ones + 4'h1;
        end
      end else begin
        cyc <= cyc + `DCTG_CNT_W'(1);
      end
    end
  end

  // Plain level output, no carrier; the pulse width alone carries the symbol
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_time_code <= 1'b0;
      o_outputs_enabled_indicator <= 1'b0;
    end else begin
      o_outputs_enabled_indicator <= i_synced;
      o_time_code <= i_synced && !i_pps && (state == dctg_pkg::DCTG_SEND) && (cyc < width);
    end
  end

  // Helper for the checks: length of the current high run
  logic [`DCTG_CNT_W-1:0] hi_run;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      hi_run <= '0;
    end else begin
      hi_run <= o_time_code ? hi_run + `DCTG_CNT_W'(1) : '0;
    end
  end

  sequence s_elem_end;
    (state == dctg_pkg::DCTG_SEND) && (cyc == ELEM_LAST) && !i_pps && i_synced;
  endsequence

  sequence s_elem_restart;
    cyc == '0;
  endsequence

  property p_width_legal;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      $fell(o_time_code) && i_synced |-> (hi_run == ZERO_W) || (hi_run == ONE_W) || (hi_run == MARK_W);
  endproperty
  a_width_legal: assert property (p_width_legal) else $error("pulse width is not zero, one or marker");

  property p_marker_width;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      $fell(o_time_code) && i_synced && is_marker |-> hi_run == MARK_W;
  endproperty
  a_marker_width: assert property (p_marker_width) else $error("marker element width wrong");

  property p_elem_period;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      s_elem_end |=> s_elem_restart;
  endproperty
  a_elem_period: assert property (p_elem_period) else $error("element period wrong");

  property p_pps_start;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      i_pps && i_synced |=> (state == dctg_pkg::DCTG_SEND) && (idx == 7'h00) && (cyc == '0) ##1 o_time_code;
  endproperty
  a_pps_start: assert property (p_pps_start) else $error("frame not aligned to pps");

  property p_disabled_low;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !i_synced |=> !o_time_code && !o_outputs_enabled_indicator;
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("output active while unsynchronised");

  property p_year_gap;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !frame[54] && !frame[61] && (frame[58:55] == $past(year_bcd[7:4]) || !($past(i_pps) && $past(i_synced)));
  endproperty
  a_year_gap: assert property (p_year_gap) else $error("year field or fixed zero bits wrong");

  property p_parity;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      frame[75] == ^frame[74:0];
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");

  property p_quality_clear;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      first_sync_event |=> (clock_quality_figure == 4'h0) && first_sync_done;
  endproperty
  a_quality_clear: assert property (p_quality_clear) else $error("quality figure not cleared on first lock");

  property p_sbs_gated;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      i_pps && i_synced && !ext_format |=> frame[97:80] == '0;
  endproperty
  a_sbs_gated: assert property (p_sbs_gated) else $error("binary seconds sent in basic format");

endmodule // dctg_time_code_gen

//--- verif/dctg_rx_model.sv
// Behavioural time code receiver that decodes pulse widths into one frame
`timescale 1ns/100ps
module dctg_rx_model #(
  parameter int ZERO_CYCLES = 10,
  parameter int ONE_CYCLES = 25,
  parameter int MARK_CYCLES = 40
) (
  input wire logic i_ref_clk,
  input wire logic i_line,
  input wire logic i_restart,
  output logic [99:0] o_ones,
  output logic [99:0] o_marks,
  output logic [7:0] o_count,
  output logic o_bad
);
  int width = 0;
  logic last = 1'b0;
  // Exact widths only: a receiver with tolerance would hide an off-by-one count
  always @(posedge i_ref_clk) begin
    last <= i_line;
    if (i_restart) begin
      o_ones <= '0;
      o_marks <= '0;
      o_count <= 8'h00;
      o_bad <= 1'b0;
      width <= 0;
    end else if (i_line) begin
      width <= width + 1;
    end else if (last) begin
      width <= 0;
      o_count <= o_count + 8'h01;
      if (o_count > 8'h63) begin
        o_bad <= 1'b1;
      end else if (width == ONE_CYCLES) begin
        o_ones[o_count] <= 1'b1;
      end else if (width == MARK_CYCLES) begin
        o_marks[o_count] <= 1'b1;
      end else if (width != ZERO_CYCLES) begin
        o_bad <= 1'b1;
      end
    end
  end
endmodule // dctg_rx_model

//--- verif/testbench.sv
// Self-checking bench for the time code generator
`timescale 1ns/100ps
`include "dctg_regs.svh"
module testbench;
  logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_pps = 1'b0, i_synced = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, restart = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, time_code, enabled, bad, err;
  logic [99:0] ones, marks, exp_ones, exp_marks;
  logic [7:0] count;
  int n_errors = 0, check_count = 0, cycles = 0;
  always #20 i_ref_clk = ~i_ref_clk;
  dctg_time_code_gen #(.ELEM_CYCLES(50), .ZERO_CYCLES(10), .ONE_CYCLES(25), .MARK_CYCLES(40)) u_dut (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_pps(i_pps), .i_synced(i_synced), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_time_code(time_code), .o_outputs_enabled_indicator(enabled));
  dctg_rx_model u_rx (
    .i_ref_clk(i_ref_clk), .i_line(time_code), .i_restart(restart), .o_ones(ones), .o_marks(marks),
    .o_count(count), .o_bad(bad));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Ceiling of eight frames of 5000 cycles covers three frame-length runs plus register traffic
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
  task automatic chk(input string name, input logic [99:0] seen, input logic [99:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, seen);
      n_errors = n_errors + 1;
    end
  endtask
  // Request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do @(posedge i_ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send_pps();
    @(posedge i_ref_clk);
    restart <= 1'b0;
    i_pps <= 1'b1;
    @(posedge i_ref_clk);
    i_pps <= 1'b0;
  endtask
  task automatic frame(input logic ext);
    @(posedge i_ref_clk);
    restart <= 1'b1;
    send_pps();
    @(negedge i_ref_clk);
    chk("line before start", time_code, 1'b0);
    @(negedge i_ref_clk);
    chk("line at start", time_code, 1'b1);
    repeat (5010) @(negedge i_ref_clk);
    exp_marks = '0;
    exp_marks[0] = 1'b1;
    for (int i = 9; i < 100; i = i + 10) exp_marks[i] = 1'b1;
    exp_ones = '0;
    exp_ones[4:1] = 4'h7;
    exp_ones[8:6] = 3'h3;
    exp_ones[13:10] = 4'h9;
    exp_ones[17:15] = 3'h5;
    exp_ones[23:20] = 4'h3;
    exp_ones[26:25] = 2'h2;
    exp_ones[33:30] = 4'h5;
    exp_ones[38:35] = 4'h6;
    exp_ones[41:40] = 2'h3;
    exp_ones[53:50] = 4'h7;
    exp_ones[58:55] = 4'h4;
    exp_ones[64:60] = 5'h1D;
    exp_ones[68:65] = 4'h5;
    exp_ones[70] = 1'b1;
    exp_ones[74:71] = 4'h6;
    exp_ones[75] = ^exp_ones[74:0];
    if (ext) begin
      exp_ones[88:80] = 9'h003;
      exp_ones[97:90] = 8'h80;
    end
    chk("marker layout", marks, exp_marks);
    chk("frame bits", ones, exp_ones);
    chk("width fault", bad, 1'b0);
    chk("element count", count, 8'h64);
  endtask
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    apb(1'b0, `DCTG_OFS_QUALITY, 32'h0);
    chk("quality at reset", rd, 32'hF);
    chk("indicator unsynced", enabled, 1'b0);
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped error", err, 1'b1);
    apb(1'b1, `DCTG_OFS_FLAGS, 32'h0000_015F);
    apb(1'b0, `DCTG_OFS_FLAGS, 32'h0);
    chk("flags readback", rd, 32'h0000_015F);
    chk("flags error", err, 1'b0);
    i_synced <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    apb(1'b0, `DCTG_OFS_QUALITY, 32'h0);
    chk("quality at first sync", rd, 32'h0);
    chk("indicator synced", enabled, 1'b1);
    apb(1'b0, `DCTG_OFS_STATUS, 32'h0);
    chk("status synced", rd, 32'h5);
    apb(1'b1, `DCTG_OFS_CTRL, 32'h1);
    apb(1'b1, `DCTG_OFS_TIME, 32'h0023_5937);
    apb(1'b1, `DCTG_OFS_DATE, 32'h0047_0365);
    apb(1'b1, `DCTG_OFS_BIN_SECONDS, 32'h0001_0003);
    apb(1'b1, `DCTG_OFS_QUALITY, 32'h6);
    frame(1'b1);
    apb(1'b1, `DCTG_OFS_CTRL, 32'h0);
    frame(1'b0);
    // Losing sync mid-frame must silence the line at once
    @(posedge i_ref_clk);
    restart <= 1'b1;
    send_pps();
    repeat (500) @(posedge i_ref_clk);
    i_synced <= 1'b0;
    repeat (2) @(negedge i_ref_clk);
    chk("line after sync loss", time_code, 1'b0);
    chk("indicator after loss", enabled, 1'b0);
    repeat (5000) @(negedge i_ref_clk);
    chk("frame cut short", count < 8'h64, 1'b1);
    report_and_stop();
  end
endmodule // testbench
